// ---- common/tfm_defines.svh ----
`ifndef TFM_DEFINES_SVH
`define TFM_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TFM_OFF_INTEG_DRIVE   12'hEF0
`define TFM_OFF_INTEG_SAMPLE  12'hEF4
`define TFM_OFF_INTEG_MODE    12'hF00
`define TFM_OFF_CLAIM_SET     12'hFA0
`define TFM_OFF_CLAIM_CLR     12'hFA4
`define TFM_OFF_LOCK_KEY      12'hFB0
`define TFM_OFF_LOCK_STATE    12'hFB4
`define TFM_OFF_SEC_LEVEL     12'hFB8

// ****************************************************************
// widths and field positions
// ****************************************************************
`define TFM_ADDR_W            12
`define TFM_DATA_W            32
`define TFM_BE_W              4
`define TFM_PIN_W             8
`define TFM_CLAIM_W           4
`define TFM_BIT_INTEG_EN      0
`define TFM_BIT_LOCK_PRESENT  0
`define TFM_BIT_LOCK_ENGAGED  1
`define TFM_BIT_KEY_WIDTH     2
`define TFM_BE_LANE0          0

// ****************************************************************
// values
// ****************************************************************
`define TFM_UNLOCK_KEY        32'hC5ACCE55
`define TFM_BE_FULL           4'hF
`define TFM_CLAIM_IMPL        4'hF
`define TFM_KEY_WIDTH_32      1'h0
`define TFM_SEC_LEVEL_VAL     32'h0000_0000
`define TFM_RST_WORD          32'h0000_0000
`define TFM_RST_PINS          8'h00
`define TFM_RST_CLAIM         4'h0
`define TFM_RST_INTEG         1'h0
`define TFM_RST_LOCKED        1'h1
`define TFM_RST_WAIT          1'h1
`define TFM_RST_CLAIM_BIT     1'h0
`define TFM_LOCK_PRESENT      1'h1

`endif

// ---- common/tfm_pkg.sv ----
package tfm_pkg;

  // bus slave handshake states
  typedef enum logic {
    TFM_IDLE,
    TFM_ACK
  } tfm_state_t;

  // decoded register select
  typedef enum logic [3:0] {
    TFM_SEL_NONE,
    TFM_SEL_INTEG_DRIVE,
    TFM_SEL_INTEG_SAMPLE,
    TFM_SEL_INTEG_MODE,
    TFM_SEL_CLAIM_SET,
    TFM_SEL_CLAIM_CLR,
    TFM_SEL_LOCK_KEY,
    TFM_SEL_LOCK_STATE,
    TFM_SEL_SEC_LEVEL
  } tfm_sel_t;

endpackage

// ---- rtl/tfm_lock_ctrl.sv ----
`timescale 1ns/1ps
`include "tfm_defines.svh"

module tfm_lock_ctrl (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   keyWrite,
  input  wire logic [`TFM_DATA_W-1:0] keyData,
  input  wire logic [`TFM_BE_W-1:0]   keyLanes,
  output logic                        lockEngaged_q
);

  logic keyMatch;

  // ****************************************************************
  // key compare
  // ****************************************************************
  // a partial-word write can never carry the whole key, so it locks
  assign keyMatch = (keyData == `TFM_UNLOCK_KEY) && (keyLanes == `TFM_BE_FULL);

  // ****************************************************************
  // lock state
  // ****************************************************************
  // starts engaged so stray on-chip writes after reset are refused
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lockEngaged_q <= `TFM_RST_LOCKED;
    end else if (keyWrite) begin
      lockEngaged_q <= !keyMatch;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_key_release: assert property (keyWrite && keyMatch |=> !lockEngaged_q)
    else $error("right key did not release the lock");

  a_key_engage: assert property (keyWrite && !keyMatch |=> lockEngaged_q)
    else $error("wrong key did not engage the lock");

  a_lock_stable: assert property (!keyWrite |=> $stable(lockEngaged_q))
    else $error("lock changed without a key write");

endmodule

// ---- rtl/tfm_mgmt_regs.sv ----
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "tfm_defines.svh"

module tfm_mgmt_regs (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic [`TFM_ADDR_W-1:0] address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [`TFM_DATA_W-1:0] writedata,
  input  wire logic [`TFM_BE_W-1:0]   byteenable,
  input  wire logic                   fromDebugger,
  input  wire logic [`TFM_PIN_W-1:0]  funcOutputs,
  input  wire logic [`TFM_PIN_W-1:0]  componentInputs,
  output logic [`TFM_DATA_W-1:0]      readdata,
  output logic                        waitrequest,
  output logic                        integrationModeOn,
  output logic [`TFM_PIN_W-1:0]       componentOutputs
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  tfm_pkg::tfm_state_t          state_q;
  tfm_pkg::tfm_state_t          state_d;
  tfm_pkg::tfm_sel_t            sel;
  logic                         waitReq_q;
  logic [`TFM_DATA_W-1:0]       readData_q;
  logic [`TFM_DATA_W-1:0]       readData_d;
  logic                         integMode_q;
  logic [`TFM_PIN_W-1:0]        integDrive_q;
  logic [`TFM_PIN_W-1:0]        pinsOut_q;
  logic [`TFM_PIN_W-1:0]        pinsOut_d;
  logic [`TFM_CLAIM_W-1:0]      claim_q;
  logic                         lockEngaged;
  logic                         reqSeen;
  logic                         wrCommit;
  logic                         wrAllowed;
  logic                         wrLane0;
  logic                         keyWrite;
  logic [`TFM_DATA_W-1:0]       lockReport;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one decoder serves both the read mux and the write strobes
  function automatic tfm_pkg::tfm_sel_t decodeSel(input logic [`TFM_ADDR_W-1:0] a);
    tfm_pkg::tfm_sel_t s;
    s = tfm_pkg::TFM_SEL_NONE;
    unique case (a)
      `TFM_OFF_INTEG_DRIVE:  s = tfm_pkg::TFM_SEL_INTEG_DRIVE;
      `TFM_OFF_INTEG_SAMPLE: s = tfm_pkg::TFM_SEL_INTEG_SAMPLE;
      `TFM_OFF_INTEG_MODE:   s = tfm_pkg::TFM_SEL_INTEG_MODE;
      `TFM_OFF_CLAIM_SET:    s = tfm_pkg::TFM_SEL_CLAIM_SET;
      `TFM_OFF_CLAIM_CLR:    s = tfm_pkg::TFM_SEL_CLAIM_CLR;
      `TFM_OFF_LOCK_KEY:     s = tfm_pkg::TFM_SEL_LOCK_KEY;
      `TFM_OFF_LOCK_STATE:   s = tfm_pkg::TFM_SEL_LOCK_STATE;
      `TFM_OFF_SEC_LEVEL:    s = tfm_pkg::TFM_SEL_SEC_LEVEL;
      default:               s = tfm_pkg::TFM_SEL_NONE;
    endcase
    return s;
  endfunction

  assign sel = decodeSel(address);

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // each access costs one wait cycle: the request is seen in idle,
  // answered with waitrequest low in the next cycle, then released
  assign reqSeen = (state_q == tfm_pkg::TFM_IDLE) && (read || write);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tfm_pkg::TFM_IDLE: begin
        if (read || write) begin
          state_d = tfm_pkg::TFM_ACK;
        end
      end
      tfm_pkg::TFM_ACK: begin
        state_d = tfm_pkg::TFM_IDLE;
      end
    endcase
  end

  // handshake state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= tfm_pkg::TFM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // waitrequest is high at rest so a new request always stalls first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      waitReq_q <= `TFM_RST_WAIT;
    end else begin
      waitReq_q <= !reqSeen;
    end
  end

  assign waitrequest = waitReq_q;

  // ****************************************************************
  // write qualification
  // ****************************************************************
  // writes land on the edge where the master sees waitrequest low
  assign wrCommit  = (state_q == tfm_pkg::TFM_ACK) && write;
  assign wrAllowed = fromDebugger || !lockEngaged
                     || (sel == tfm_pkg::TFM_SEL_LOCK_KEY);
  assign wrLane0   = wrCommit && wrAllowed && byteenable[`TFM_BE_LANE0];
  // the debugger sees no lock, so its key writes are dropped
  assign keyWrite  = wrCommit && !fromDebugger
                     && (sel == tfm_pkg::TFM_SEL_LOCK_KEY);

  // ****************************************************************
  // software lock
  // ****************************************************************
  tfm_lock_ctrl tfm_lock_ctrl_inst (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .keyWrite      (keyWrite),
    .keyData       (writedata),
    .keyLanes      (byteenable),
    .lockEngaged_q (lockEngaged)
  );

  // ****************************************************************
  // integration mode switch
  // ****************************************************************
  // functional mode after reset; only bit 0 is stored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      integMode_q <= `TFM_RST_INTEG;
    end else if (wrLane0 && sel == tfm_pkg::TFM_SEL_INTEG_MODE) begin
      integMode_q <= writedata[`TFM_BIT_INTEG_EN];
    end
  end

  // value software places on the outputs while in integration mode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      integDrive_q <= `TFM_RST_PINS;
    end else if (wrLane0 && sel == tfm_pkg::TFM_SEL_INTEG_DRIVE) begin
      integDrive_q <= writedata[`TFM_PIN_W-1:0];
    end
  end

  // ****************************************************************
  // output pins
  // ****************************************************************
  // integration mode takes the outputs away from the functional path;
  // the functional value is lost until the switch is cleared
  genvar gp;
  generate
    for (gp = 0; gp < `TFM_PIN_W; gp++) begin : g_pin
      assign pinsOut_d[gp] = integMode_q ? integDrive_q[gp] : funcOutputs[gp];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pinsOut_q <= `TFM_RST_PINS;
    end else begin
      pinsOut_q <= pinsOut_d;
    end
  end

  assign componentOutputs  = pinsOut_q;
  assign integrationModeOn = integMode_q;

  // ****************************************************************
  // claim tag
  // ****************************************************************
  // the tag is stored only; nothing but the read mux (claim clear view) reads it
  genvar gc;
  generate
    for (gc = 0; gc < `TFM_CLAIM_W; gc++) begin : g_claim
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          claim_q[gc] <= `TFM_RST_CLAIM_BIT;
        end else if (wrLane0 && sel == tfm_pkg::TFM_SEL_CLAIM_SET && writedata[gc]) begin
          claim_q[gc] <= 1'h1;
        end else if (wrLane0 && sel == tfm_pkg::TFM_SEL_CLAIM_CLR && writedata[gc]) begin
          claim_q[gc] <= 1'h0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read mux
  // ****************************************************************
  // the lock report depends on which interface asks
  assign lockReport = fromDebugger ? `TFM_RST_WORD
                    : {{(`TFM_DATA_W-3){1'b0}}, `TFM_KEY_WIDTH_32, lockEngaged,
                       `TFM_LOCK_PRESENT};

  // reads are never gated by the lock; unmapped words read zero
  always_comb begin
    readData_d = `TFM_RST_WORD;
    unique case (sel)
      tfm_pkg::TFM_SEL_INTEG_DRIVE:  readData_d[`TFM_PIN_W-1:0] = integDrive_q;
      tfm_pkg::TFM_SEL_INTEG_SAMPLE: readData_d[`TFM_PIN_W-1:0] = componentInputs;
      tfm_pkg::TFM_SEL_INTEG_MODE:   readData_d[`TFM_BIT_INTEG_EN] = integMode_q;
      tfm_pkg::TFM_SEL_CLAIM_SET:    readData_d[`TFM_CLAIM_W-1:0] = `TFM_CLAIM_IMPL;
      tfm_pkg::TFM_SEL_CLAIM_CLR:    readData_d[`TFM_CLAIM_W-1:0] = claim_q;
      tfm_pkg::TFM_SEL_LOCK_KEY:     readData_d = `TFM_RST_WORD;
      tfm_pkg::TFM_SEL_LOCK_STATE:   readData_d = lockReport;
      tfm_pkg::TFM_SEL_SEC_LEVEL:    readData_d = `TFM_SEC_LEVEL_VAL;
      tfm_pkg::TFM_SEL_NONE:         readData_d = `TFM_RST_WORD;
    endcase
  end

  // read data is captured as the request is seen and held until next read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      readData_q <= `TFM_RST_WORD;
    end else if (reqSeen && read) begin
      readData_q <= readData_d;
    end
  end

  assign readdata = readData_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_req;
    (state_q == tfm_pkg::TFM_IDLE) && (read || write);
  endsequence

  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  a_one_wait_answer: assert property (s_req |=> s_answer)
    else $error("access was not answered after one wait cycle");

  a_integ_mode_write: assert property (
    wrCommit && wrAllowed && byteenable[0] && sel == tfm_pkg::TFM_SEL_INTEG_MODE
    |=> integMode_q == $past(writedata[0]) ##1 componentOutputs == (integMode_q ?
        integDrive_q : $past(funcOutputs)))
    else $error("integration mode switch or pins wrong after write");

  a_claim_set_bits: assert property (
    wrCommit && wrAllowed && byteenable[0] && sel == tfm_pkg::TFM_SEL_CLAIM_SET
    |=> claim_q == ($past(claim_q) | $past(writedata[3:0])))
    else $error("claim set view did not or-in the written bits");

  a_claim_clr_bits: assert property (
    wrCommit && wrAllowed && byteenable[0] && sel == tfm_pkg::TFM_SEL_CLAIM_CLR
    |=> claim_q == ($past(claim_q) & ~$past(writedata[3:0])))
    else $error("claim clear view did not clear the written bits");

  a_locked_refused: assert property (
    wrCommit && lockEngaged && !fromDebugger && sel != tfm_pkg::TFM_SEL_LOCK_KEY
    |=> $stable(integMode_q) && $stable(claim_q) && $stable(integDrive_q))
    else $error("on-chip write changed state while locked");

  a_debug_not_blocked: assert property (
    wrCommit && fromDebugger && lockEngaged && byteenable[0]
    && sel == tfm_pkg::TFM_SEL_INTEG_MODE
    |=> integMode_q == $past(writedata[0]) && lockEngaged)
    else $error("debugger write was blocked or moved the lock");

  a_lock_report_debug: assert property (
    s_req and (read && fromDebugger && sel == tfm_pkg::TFM_SEL_LOCK_STATE)
    |=> readdata == 32'h0000_0000)
    else $error("lock report not zero from debugger");

  a_lock_report_chip: assert property (
    s_req and (read && !fromDebugger && sel == tfm_pkg::TFM_SEL_LOCK_STATE)
    |=> readdata == {29'h0, 1'b0, $past(lockEngaged), 1'b1})
    else $error("lock report wrong on the on-chip interface");

  a_claim_read_back: assert property (
    s_req and (read && sel == tfm_pkg::TFM_SEL_CLAIM_CLR)
    |=> readdata == {28'h0, $past(claim_q)})
    else $error("claim clear view did not return the tag");

  a_sec_level_zero: assert property (
    s_req and (read && sel == tfm_pkg::TFM_SEL_SEC_LEVEL)
    |=> readdata == 32'h0000_0000)
    else $error("security level report not zero");

  a_claim_set_read: assert property (
    s_req and (read && sel == tfm_pkg::TFM_SEL_CLAIM_SET)
    |=> readdata == {28'h0, `TFM_CLAIM_IMPL})
    else $error("claim set view did not report four claim bits");

  a_mode_reserved_zero: assert property (
    s_req and (read && sel == tfm_pkg::TFM_SEL_INTEG_MODE)
    |=> readdata[`TFM_DATA_W-1:1] == 31'h0)
    else $error("reserved bits of the mode switch not zero");

  a_key_reads_zero: assert property (
    s_req and (read && sel == tfm_pkg::TFM_SEL_LOCK_KEY)
    |=> readdata == 32'h0000_0000)
    else $error("lock key entry did not read zero");

  a_key_width_bit: assert property (
    s_req and (read && sel == tfm_pkg::TFM_SEL_LOCK_STATE)
    |=> readdata[`TFM_BIT_KEY_WIDTH] == 1'h0)
    else $error("key width indicator not zero");

  a_debug_key_ignored: assert property (
    wrCommit && fromDebugger && sel == tfm_pkg::TFM_SEL_LOCK_KEY
    |=> $stable(lockEngaged))
    else $error("debugger key write moved the lock");

  // the sampled reset keeps the release edge out, where the pins still hold zero
  a_pins_integ_drive: assert property (
    resetn && integMode_q
    |=> componentOutputs == $past(integDrive_q))
    else $error("outputs do not show the integration drive value");

  a_pins_func_path: assert property (
    resetn && !integMode_q
    |=> componentOutputs == $past(funcOutputs))
    else $error("outputs do not follow the functional value");

endmodule

// ---- verification/test_tfm_mgmt_regs.sv ----
`timescale 1ns/1ps
`include "tfm_defines.svh"

module test_tfm_mgmt_regs;

  // ****************************************************************
  // stimulus and observation signals
  // ****************************************************************
  logic                   core_clk;
  logic                   resetn;
  logic [`TFM_ADDR_W-1:0] address;
  logic                   read;
  logic                   write;
  logic [`TFM_DATA_W-1:0] writedata;
  logic [`TFM_BE_W-1:0]   byteenable;
  logic                   fromDebugger;
  logic [`TFM_PIN_W-1:0]  funcOutputs;
  logic [`TFM_PIN_W-1:0]  componentInputs;
  logic [`TFM_DATA_W-1:0] readdata;
  logic                   waitrequest;
  logic                   integrationModeOn;
  logic [`TFM_PIN_W-1:0]  componentOutputs;
  int                     errTotal;
  int                     nChecks;
  logic [`TFM_DATA_W-1:0] rdVal;

  tfm_mgmt_regs tfm_mgmt_regs_inst (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .address           (address),
    .read              (read),
    .write             (write),
    .writedata         (writedata),
    .byteenable        (byteenable),
    .fromDebugger      (fromDebugger),
    .funcOutputs       (funcOutputs),
    .componentInputs   (componentInputs),
    .readdata          (readdata),
    .waitrequest       (waitrequest),
    .integrationModeOn (integrationModeOn),
    .componentOutputs  (componentOutputs)
  );

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  // ****************************************************************
  // helper tasks
  // ****************************************************************
  // verdict and end of run, shared by the main sequence and the watchdog
  task automatic wrap_up();
    if (errTotal == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus cycle; the leading edge keeps an idle cycle between requests
  task automatic bus_op(input logic isWr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] be, input logic dbg);
    @(posedge core_clk);
    address      <= a;
    writedata    <= d;
    byteenable   <= be;
    fromDebugger <= dbg;
    write        <= isWr;
    read         <= ~isWr;
    // no local limit: only the watchdog ends a wait that is never answered
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rdVal = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic dbg);
    bus_op(1'b1, a, d, `TFM_BE_FULL, dbg);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic dbg, input logic [31:0] exp);
    bus_op(1'b0, a, 32'h0000_0000, `TFM_BE_FULL, dbg);
    check(rdVal, exp);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0; resetn = 1'b0; address = 12'h000; read = 1'b0; write = 1'b0;
    writedata = 32'h0000_0000; byteenable = 4'h0; fromDebugger = 1'b0;
    funcOutputs = 8'h3C; componentInputs = 8'h96; errTotal = 0; nChecks = 0;
    do_reset();
    // reset state seen from both interfaces
    check({31'h0, integrationModeOn}, 32'h0000_0000);
    rd_chk(`TFM_OFF_INTEG_MODE, 1'b0, 32'h0000_0000);
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b0, 32'h0000_0003);
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b1, 32'h0000_0000);
    rd_chk(`TFM_OFF_CLAIM_SET, 1'b0, 32'h0000_000F);
    rd_chk(`TFM_OFF_CLAIM_CLR, 1'b0, 32'h0000_0000);
    rd_chk(`TFM_OFF_SEC_LEVEL, 1'b0, 32'h0000_0000);
    // locked: on-chip write refused, read still served
    wr(`TFM_OFF_INTEG_MODE, 32'h0000_0001, 1'b0);
    rd_chk(`TFM_OFF_INTEG_MODE, 1'b0, 32'h0000_0000);
    wr(`TFM_OFF_CLAIM_SET, 32'h0000_0003, 1'b0);
    rd_chk(`TFM_OFF_CLAIM_CLR, 1'b0, 32'h0000_0000);
    // debugger is never blocked, and its key writes change nothing
    wr(`TFM_OFF_INTEG_MODE, 32'hFFFF_FFFF, 1'b1);
    rd_chk(`TFM_OFF_INTEG_MODE, 1'b1, 32'h0000_0001);
    check({31'h0, integrationModeOn}, 32'h0000_0001);
    wr(`TFM_OFF_LOCK_KEY, `TFM_UNLOCK_KEY, 1'b1);
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b0, 32'h0000_0003);
    // unlock, then every way of engaging again
    wr(`TFM_OFF_LOCK_KEY, `TFM_UNLOCK_KEY, 1'b0);
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b0, 32'h0000_0001);
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b1, 32'h0000_0000);
    wr(`TFM_OFF_LOCK_KEY, 32'hC5ACCE54, 1'b0);
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b0, 32'h0000_0003);
    wr(`TFM_OFF_LOCK_KEY, `TFM_UNLOCK_KEY, 1'b0);
    bus_op(1'b1, `TFM_OFF_LOCK_KEY, `TFM_UNLOCK_KEY, 4'h7, 1'b0);
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b0, 32'h0000_0003);
    wr(`TFM_OFF_LOCK_KEY, `TFM_UNLOCK_KEY, 1'b0);
    rd_chk(`TFM_OFF_LOCK_KEY, 1'b0, 32'h0000_0000);
    // claim tag: set and clear only touch bits written as one
    wr(`TFM_OFF_CLAIM_SET, 32'h0000_0005, 1'b0);
    rd_chk(`TFM_OFF_CLAIM_CLR, 1'b0, 32'h0000_0005);
    wr(`TFM_OFF_CLAIM_SET, 32'hFFFF_FFF2, 1'b0);
    rd_chk(`TFM_OFF_CLAIM_CLR, 1'b0, 32'h0000_0007);
    wr(`TFM_OFF_CLAIM_CLR, 32'h0000_0003, 1'b0);
    rd_chk(`TFM_OFF_CLAIM_CLR, 1'b0, 32'h0000_0004);
    rd_chk(`TFM_OFF_CLAIM_SET, 1'b0, 32'h0000_000F);
    check({31'h0, integrationModeOn}, 32'h0000_0001);
    // integration mode: software drives outputs and samples inputs
    wr(`TFM_OFF_INTEG_DRIVE, 32'h0000_00A5, 1'b0);
    repeat (3) @(posedge core_clk);
    check({24'h0, componentOutputs}, 32'h0000_00A5);
    rd_chk(`TFM_OFF_INTEG_SAMPLE, 1'b0, 32'h0000_0096);
    rd_chk(`TFM_OFF_INTEG_DRIVE, 1'b0, 32'h0000_00A5);
    funcOutputs <= 8'h5A;
    repeat (3) @(posedge core_clk);
    check({24'h0, componentOutputs}, 32'h0000_00A5);
    // back to functional mode: outputs follow the functional value
    wr(`TFM_OFF_INTEG_MODE, 32'h0000_0000, 1'b0);
    repeat (3) @(posedge core_clk);
    check({31'h0, integrationModeOn}, 32'h0000_0000);
    check({24'h0, componentOutputs}, 32'h0000_005A);
    // an unmapped place reads zero and ignores writes; a misaligned one reads zero
    wr(12'hF04, 32'hFFFF_FFFF, 1'b0);
    rd_chk(12'hF04, 1'b0, 32'h0000_0000);
    rd_chk(12'hF01, 1'b0, 32'h0000_0000);
    // second reset in mid-run re-engages the lock and clears state
    do_reset();
    rd_chk(`TFM_OFF_LOCK_STATE, 1'b0, 32'h0000_0003);
    rd_chk(`TFM_OFF_CLAIM_CLR, 1'b0, 32'h0000_0000);
    wrap_up();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(50 * 4000);
    errTotal++;
    wrap_up();
  end

endmodule
